// ### rtl/pm_csr.sv
/*
 Power-management control/status registers behind configuration accesses.
 Assumes a decoded configuration request: one-cycle rd/wr pulse with byte
 address and byte enables; read data is registered the next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pm_csr_defs.svh"
module pm_csr (
   input wire logic clk,
   input wire logic rst_n,
   input wire pm_csr_pkg::cfg_req_t req,
   input wire logic d3cold_wake,
   input wire logic [3:0] states_supported,
   input wire logic wake_event,
   output logic [31:0] rdata,
   output logic rvalid,
   output logic wake_n,
   output logic [1:0] power_state_field
);
   // ************************************************************
   // Decode
   // ************************************************************
   logic hit, wr_lo, wr_hi;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic ws, we;
   pm_csr_pkg::power_state_t pwr_state;
   // Control/status word and bridge byte share one dword at base + 4.
   assign hit = req.addr[7:2] == 6'((`CAP_BASE + `OFS_CTRL_STATUS) >> 2);
   assign wr_lo = req.wr && hit && req.be[0];
   assign wr_hi = req.wr && hit && req.be[1];
   // ************************************************************
   // Fields
   // ************************************************************
   power_state_ctl u_state (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_lo),
      .wr_val(req.wdata[`STATE_HI:`STATE_LO]),
      .supported(states_supported),
      .state(pwr_state)
   );
   // Only the upper byte carries the wake bits.
   wake_event_ctl u_wake (
      .clk(clk),
      .rst_n(rst_n),
      .d3cold_wake(d3cold_wake),
      .wake_event(wake_event),
      .wr_en(wr_hi),
      .wr_status(req.wdata[`BIT_WAKE_STATUS]),
      .wr_enable(req.wdata[`BIT_WAKE_ENABLE]),
      .wake_event_status(ws),
      .wake_event_enable(we),
      .wake_n(wake_n)
   );
   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = req.rd;
      if (req.rd) begin
         rdata_d = 32'h0;
         if (hit) begin
            rdata_d[`BIT_WAKE_STATUS] = ws;
            rdata_d[`SCALE_HI:`SCALE_LO] = `SCALE_NO_DATA;
            rdata_d[`SELECT_HI:`SELECT_LO] = `SELECT_NO_DATA;
            rdata_d[`BIT_WAKE_ENABLE] = we;
            rdata_d[7:2] = 6'h0;
            rdata_d[`STATE_HI:`STATE_LO] = 2'(pwr_state);
            rdata_d[23:16] = `BRIDGE_EXT_RESET;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end
   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign power_state_field = 2'(pwr_state);
   read_state_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd && hit) |=> rdata_q[1:0] == 2'($past(pwr_state)))
      else $error("read power state mismatch");
   wake_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd && hit) |=> rdata_q[15] == $past(ws) && rdata_q[8] == $past(we))
      else $error("read wake bits mismatch");
   answer_next_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd |=> rvalid_q)
      else $error("read not answered");
   bridge_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      rvalid_q |-> rdata_q[23:16] == 8'h00)
      else $error("bridge byte nonzero");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      rvalid_q |-> rdata_q[7:2] == 6'h0)
      else $error("reserved bits nonzero");
   fields_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      rvalid_q |-> rdata_q[14:9] == 6'h0)
      else $error("scale or select bits nonzero");
endmodule
`default_nettype wire

// ### rtl/pm_csr_defs.svh
/*
 Offsets, field positions, reset values and encodings of the power-management
 control/status block. Assumes inclusion by bare name from design files.
*/
`ifndef PM_CSR_DEFS_SVH
`define PM_CSR_DEFS_SVH
// Byte offsets inside the power-management capability (base 0x34).
`define CAP_BASE 8'h34
`define OFS_CTRL_STATUS 8'h04
`define OFS_BRIDGE_EXT 8'h06
`define BIT_WAKE_STATUS 15
`define BIT_WAKE_ENABLE 8
`define SCALE_HI 14
`define SCALE_LO 13
`define SELECT_HI 12
`define SELECT_LO 9
`define STATE_HI 1
`define STATE_LO 0
`define BRIDGE_EXT_RESET 8'h00
`define SCALE_NO_DATA 2'h0
`define SELECT_NO_DATA 4'h0
`endif

// ### rtl/pm_csr_pkg.sv
/*
 Types shared by the power-management block and its submodules.
 Assumes the defines header is included by the user files.
*/
`default_nettype none
package pm_csr_pkg;
   typedef enum logic [1:0] {PWR_D0, PWR_D1, PWR_D2, PWR_D3HOT} power_state_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_t;
endpackage
`default_nettype wire

// ### rtl/power_state_ctl.sv
/*
 Power-state field holder: accepts only supported encodings.
 Assumes single-cycle write strobes from the register decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module power_state_ctl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [1:0] wr_val,
   input wire logic [3:0] supported,
   output pm_csr_pkg::power_state_t state
);
   pm_csr_pkg::power_state_t state_q, state_d;
   always_comb begin
      state_d = state_q;
      // Unsupported encodings complete on the bus but are dropped.
      if (wr_en && supported[wr_val]) begin
         state_d = pm_csr_pkg::power_state_t'(wr_val);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pm_csr_pkg::PWR_D0;
      end else begin
         state_q <= state_d;
      end
   end
   assign state = state_q;
   unsupported_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && !supported[wr_val]) |=> $stable(state_q))
      else $error("unsupported power state was taken");
   supported_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && supported[wr_val]) |=> 2'(state_q) == $past(wr_val))
      else $error("supported power state was not taken");
endmodule
`default_nettype wire

// ### rtl/wake_event_ctl.sv
/*
 Wake status and enable bits with the wake output.
 Assumes sticky bits live in an auxiliary-powered domain; rst_n is the
 bus reset and only clears them when D3cold wake is unsupported.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_event_ctl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d3cold_wake,
   input wire logic wake_event,
   input wire logic wr_en,
   input wire logic wr_status,
   input wire logic wr_enable,
   output logic wake_event_status,
   output logic wake_event_enable,
   output logic wake_n
);
   logic status_q, status_d, enable_q, enable_d, clr_q;
   always_comb begin
      status_d = status_q;
      enable_d = enable_q;
      // Set wins over a clear in the same cycle.
      if (wr_en && wr_status) begin
         status_d = 1'b0;
      end
      if (wake_event) begin
         status_d = 1'b1;
      end
      if (wr_en) begin
         enable_d = wr_enable;
      end
      // Sticky bits hold through reset when D3cold wake is supported.
      if (clr_q && !d3cold_wake) begin
         status_d = 1'b0;
         enable_d = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_q <= 1'b1;
      end else begin
         clr_q <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      status_q <= status_d;
      enable_q <= enable_d;
   end
   assign wake_event_status = status_q;
   assign wake_event_enable = enable_q;
   assign wake_n = !(status_q && enable_q);
   wake_gated_a: assert property (@(posedge clk) disable iff (!rst_n)
      !enable_q |-> wake_n)
      else $error("wake asserted while disabled");
   event_sets_a: assert property (@(posedge clk) disable iff (!rst_n || clr_q)
      wake_event |=> status_q)
      else $error("wake event did not set status");
   zero_keeps_a: assert property (@(posedge clk) disable iff (!rst_n || clr_q)
      (wr_en && !wr_status && !wake_event) |=> status_q == $past(status_q))
      else $error("writing zero changed status");
   clear_one_a: assert property (@(posedge clk) disable iff (!rst_n || clr_q)
      (wr_en && wr_status && !wake_event) |=> !status_q)
      else $error("writing one did not clear status");
endmodule
`default_nettype wire

// ### bench/pci_host_model.sv
/*
 Configuration host model that issues reads and writes to the block.
 Assumes one-cycle request pulses and a read answer one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
   input wire logic clk,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   output pm_csr_pkg::cfg_req_t req
);
   initial req = '0;
   // Released fields are inverted so that stale values never look valid.
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, be: b, wdata: d & 32'hffff_ff03};
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, wdata: ~d};
   endtask
   task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge clk);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hf, wdata: 32'h0};
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: 32'hffff_ffff};
      d = (rvalid === 1'b1) ? rdata : 32'hxxxx_xxxx;
   endtask
endmodule
`default_nettype wire

// ### bench/tb_pci_power_mgmt_control_status.sv
/*
 Self-checking bench for the power-management register block.
 Assumes the host model in its own file and states D0, D1, D3hot supported.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pci_power_mgmt_control_status;
   logic clk, rst_n, wake_event, d3cold_wake, rvalid, wake_n;
   logic [3:0] states_supported;
   logic [31:0] rdata, rd_val;
   logic [1:0] power_state_field;
   pm_csr_pkg::cfg_req_t req;
   int err_count, num_checks, cycles;
   typedef struct {logic [31:0] wdata; logic [1:0] state;} row_t;
   row_t rows [5] = '{'{32'h1, 2'h1}, '{32'h3, 2'h3}, '{32'h2, 2'h3}, '{32'h0, 2'h0},
                      '{32'h2, 2'h0}};
   pm_csr dut (.clk(clk), .rst_n(rst_n), .req(req), .d3cold_wake(d3cold_wake),
      .states_supported(states_supported), .wake_event(wake_event), .rdata(rdata),
      .rvalid(rvalid), .wake_n(wake_n), .power_state_field(power_state_field));
   pci_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // The run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   // ************************************
   // Main sequence
   // ************************************
   initial begin
      rst_n = 1'b0;
      wake_event = 1'b0;
      d3cold_wake = 1'b0;
      states_supported = 4'hb;
      repeat (16) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (2) @(negedge clk);
      host.cfg_rd(8'h38, rd_val);
      chk(rd_val, 32'h0);
      foreach (rows[i]) begin
         host.cfg_wr(8'h38, 4'h1, rows[i].wdata);
         host.cfg_rd(8'h38, rd_val);
         chk(rd_val, {30'h0, rows[i].state});
         chk(32'(power_state_field), 32'(rows[i].state));
      end
      $display("power state test done");
      host.cfg_wr(8'h38, 4'hf, 32'h00ff_7efc);
      host.cfg_rd(8'h38, rd_val);
      chk(rd_val, 32'h0);
      host.cfg_rd(8'h3c, rd_val);
      chk(rd_val, 32'h0);
      $display("read-only field test done");
      @(negedge clk) wake_event = 1'b1;
      @(negedge clk) wake_event = 1'b0;
      repeat (2) @(negedge clk);
      chk(32'(wake_n), 32'h1);
      host.cfg_wr(8'h38, 4'h2, 32'h0);
      host.cfg_rd(8'h38, rd_val);
      chk(rd_val, 32'h8000);
      host.cfg_wr(8'h38, 4'h2, 32'h100);
      chk(32'(wake_n), 32'h0);
      host.cfg_wr(8'h38, 4'h2, 32'h8100);
      host.cfg_rd(8'h38, rd_val);
      chk(rd_val, 32'h100);
      chk(32'(wake_n), 32'h1);
      $display("wake test done");
      d3cold_wake = 1'b1;
      host.cfg_wr(8'h38, 4'h1, 32'h1);
      @(negedge clk) wake_event = 1'b1;
      @(negedge clk) wake_event = 1'b0;
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      host.cfg_rd(8'h38, rd_val);
      chk(rd_val, 32'h8100);
      chk(32'(wake_n), 32'h0);
      host.cfg_wr(8'h38, 4'h2, 32'h8000);
      host.cfg_rd(8'h38, rd_val);
      chk(rd_val, 32'h0);
      chk(32'(wake_n), 32'h1);
      $display("sticky reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire
